// ---- hdl/dac_ctrl_pkg.sv ----
// Package: register map, field layout and reset values of the converter update control
package dac_ctrl_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_CONTROL    = 4'h0;
    localparam logic [3:0] OFF_VALUE_HIGH = 4'h4;
    localparam logic [3:0] OFF_VALUE_LOW  = 4'h8;
    localparam logic [3:0] OFF_SHADOW     = 4'hc;
    // Control field positions
    localparam int CTL_AUTO_TRIGGER_BIT = 7;
    localparam int CTL_TRIG_SEL_LSB     = 4;
    localparam int CTL_TRIG_SEL_W       = 3;
    localparam int CTL_LEFT_ADJUST_BIT  = 2;
    localparam int CTL_OUTPUT_PIN_BIT   = 1;
    localparam int CTL_ENABLE_BIT       = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hf7;
    // Reset values
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] VALUE_HIGH_RESET = 8'h00;
    localparam logic [7:0] VALUE_LOW_RESET  = 8'h00;
    localparam logic [9:0] SHADOW_RESET     = 10'h000;
    // Trigger source codes
    localparam logic [2:0] TRIG_COMP0      = 3'h0;
    localparam logic [2:0] TRIG_COMP1      = 3'h1;
    localparam logic [2:0] TRIG_EXT_INT0   = 3'h2;
    localparam logic [2:0] TRIG_T0_COMPARE = 3'h3;
    localparam logic [2:0] TRIG_T0_OVF     = 3'h4;
    localparam logic [2:0] TRIG_T1_COMP_B  = 3'h5;
    localparam logic [2:0] TRIG_T1_OVF     = 3'h6;
    localparam logic [2:0] TRIG_T1_CAPTURE = 3'h7;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Assemble the 10-bit value from the register pair per justification
    function automatic logic [9:0] pair_value(input logic [7:0] high, input logic [7:0] low,
                                             input logic left);
        pair_value = left ? {high, low[7:6]} : {high[1:0], low};
    endfunction
endpackage

// ---- hdl/trigger_select.sv ----
// Trigger source multiplexer with rising-edge detection
`timescale 1ns/1ps
`default_nettype none
module trigger_select (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] flags,
    input  wire logic [2:0] select,
    output logic            rise
);
    import dac_ctrl_pkg::*;
    logic flag_sel;
    logic flag_prev_reg;

    // Flag taken regardless of its interrupt enable
    assign flag_sel = flags[select];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_prev_reg <= 1'b0;
        end else begin
            flag_prev_reg <= flag_sel;
        end
    end

    // A flag that stays high gives no second edge
    assign rise = flag_sel & ~flag_prev_reg;

    edge_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rise |=> !rise) else $error("Trigger edge lasted two cycles");
endmodule
`default_nettype wire

// ---- hdl/shadow_update.sv ----
// Shadow value holder with high-byte arming for triggered updates
`timescale 1ns/1ps
`default_nettype none
module shadow_update (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       auto_mode,
    input  wire logic       high_write,
    input  wire logic       trig,
    input  wire logic [9:0] pair,
    output logic [9:0]      shadow,
    output logic            update
);
    import dac_ctrl_pkg::*;
    logic armed_reg;
    logic [9:0] shadow_reg;

    // Normal mode loads on high write, auto mode on trigger once armed
    assign update = auto_mode ? (trig & armed_reg) : high_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_reg <= 1'b0;
        end else if (high_write) begin
            // Stays armed so 8-bit use reloads each event
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_reg <= SHADOW_RESET;
        end else if (update) begin
            shadow_reg <= pair;
        end
    end
    assign shadow = shadow_reg;

    shadow_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !update |=> $stable(shadow_reg)) else $error("Shadow changed without update");
    auto_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
        auto_mode && high_write && !trig |-> !update) else $error("Auto mode updated on write");
endmodule
`default_nettype wire

// ---- hdl/dac_update_control.sv ----
// Top level: AXI4-Lite register slave and converter update control
`timescale 1ns/1ps
`default_nettype none
module dac_update_control (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [3:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic [7:0] trigger_flags,
    output logic [9:0]      converter_value,
    output logic            converter_enable,
    output logic            analog_output_pin
);
    import dac_ctrl_pkg::*;

    // ************************************************************
    // Register bus
    // ************************************************************
    logic        aw_held_reg;
    logic [3:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        wr_fire;
    logic        rd_fire;

    logic [7:0]  converter_control_reg;
    logic [7:0]  converter_value_high_reg;
    logic [7:0]  converter_value_low_reg;
    logic        high_write;
    logic [9:0]  pair;
    logic [9:0]  shadow;
    logic        trig;
    logic        update;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (aw_addr_reg == OFF_CONTROL || aw_addr_reg == OFF_VALUE_HIGH ||
                           aw_addr_reg == OFF_VALUE_LOW || aw_addr_reg == OFF_SHADOW)
                          ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    // Only byte lane 0 carries data; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_reg <= CONTROL_RESET;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == OFF_CONTROL) begin
            converter_control_reg <= w_data_reg[7:0] & CTL_WRITE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_value_low_reg <= VALUE_LOW_RESET;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == OFF_VALUE_LOW) begin
            converter_value_low_reg <= w_data_reg[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_value_high_reg <= VALUE_HIGH_RESET;
        end else if (high_write) begin
            converter_value_high_reg <= w_data_reg[7:0];
        end
    end

    assign high_write = wr_fire && w_strb_reg[0] && aw_addr_reg == OFF_VALUE_HIGH;

    // Pair taken with the incoming high byte so a single write is complete
    // Justification is applied only as the pair enters the shadow
    assign pair = pair_value(high_write ? w_data_reg[7:0] : converter_value_high_reg,
                             converter_value_low_reg,
                             converter_control_reg[CTL_LEFT_ADJUST_BIT]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            case (s_axi_araddr)
                OFF_CONTROL:    rdata_reg <= {24'h00_0000, converter_control_reg};
                OFF_VALUE_HIGH: rdata_reg <= {24'h00_0000, converter_value_high_reg};
                OFF_VALUE_LOW:  rdata_reg <= {24'h00_0000, converter_value_low_reg};
                // Status view of the value being converted, read only
                OFF_SHADOW:     rdata_reg <= {22'h00_0000, shadow};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    // ************************************************************
    // Trigger and shadow
    // ************************************************************
    // A flag left set by software yields no new edge
    trigger_select u_trig (
        .aclk    (aclk),
        .aresetn (aresetn),
        .flags   (trigger_flags),
        .select  (converter_control_reg[CTL_TRIG_SEL_LSB +: CTL_TRIG_SEL_W]),
        .rise    (trig)
    );

    shadow_update u_shadow (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .auto_mode  (converter_control_reg[CTL_AUTO_TRIGGER_BIT]),
        .high_write (high_write),
        .trig       (trig),
        .pair       (pair),
        .shadow     (shadow),
        .update     (update)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    // The update is single-cycle, so no edge can land mid-update
    assign converter_value   = shadow;
    assign converter_enable  = converter_control_reg[CTL_ENABLE_BIT];
    // Pin driven only while the converter runs and routing is on
    assign analog_output_pin = converter_control_reg[CTL_OUTPUT_PIN_BIT] &
                               converter_control_reg[CTL_ENABLE_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    normal_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
        high_write && !converter_control_reg[CTL_AUTO_TRIGGER_BIT] |=> converter_value == $past(pair))
        else $error("Normal mode high write did not load value");
    low_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && aw_addr_reg == OFF_VALUE_LOW && !trig |=> $stable(converter_value))
        else $error("Low write changed output");
    auto_trigger_a: assert property (@(posedge aclk) disable iff (!aresetn)
        converter_control_reg[CTL_AUTO_TRIGGER_BIT] && trig && !high_write && update
        |=> converter_value == $past(pair)) else $error("Trigger did not load value");
    right_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !converter_control_reg[CTL_LEFT_ADJUST_BIT] |->
        pair[7:0] == converter_value_low_reg) else $error("Right-adjust layout wrong");
    left_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
        converter_control_reg[CTL_LEFT_ADJUST_BIT] && !high_write |->
        pair[9:2] == converter_value_high_reg) else $error("Left-adjust layout wrong");
    // The value moves on the edge after an update, so that edge is excluded
    adjust_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(converter_control_reg[CTL_LEFT_ADJUST_BIT]) && !$past(update) |-> $stable(converter_value))
        else $error("Adjust change altered output");
    enable_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && w_strb_reg[0] && aw_addr_reg == OFF_CONTROL |=> converter_enable == $past(w_data_reg[0]))
        else $error("Enable bit not followed");
    pin_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !converter_control_reg[CTL_OUTPUT_PIN_BIT] |-> !analog_output_pin)
        else $error("Pin driven while routing off");
    pin_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        analog_output_pin |-> converter_enable) else $error("Pin driven while converter off");
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid) else $error("Write response missing");

    // ************************************************************
    // Bus protocol checks
    // ************************************************************
    // Responses stand until the master takes them
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early");
    rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read response dropped early");
    read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire |=> s_axi_rvalid) else $error("Read response missing");
    bvalid_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("Write response not cleared");
    rvalid_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("Read response not cleared");
    aw_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while response pending");
    ar_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("Read accepted while response pending");
    unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not refused");
    unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && aw_addr_reg[1:0] != 2'h0 |=>
        s_axi_bresp == RESP_SLVERR && $stable(converter_control_reg) &&
        $stable(converter_value_high_reg) && $stable(converter_value_low_reg))
        else $error("Unmapped write took effect");
    mapped_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && aw_addr_reg[1:0] == 2'h0 |=> s_axi_bresp == RESP_OKAY)
        else $error("Mapped write refused");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (converter_control_reg & ~CTL_WRITE_MASK) == 8'h00)
        else $error("Reserved control bit set");
    shadow_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && aw_addr_reg == OFF_SHADOW |=> s_axi_bresp == RESP_OKAY &&
        $stable(converter_control_reg) && $stable(converter_value_high_reg) && $stable(converter_value_low_reg))
        else $error("Shadow view accepted a write");
    held_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> !aw_held_reg && !w_held_reg) else $error("Write halves not released");

    normal_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
        high_write && !converter_control_reg[CTL_AUTO_TRIGGER_BIT]);
    auto_fire_c: cover property (@(posedge aclk) disable iff (!aresetn)
        converter_control_reg[CTL_AUTO_TRIGGER_BIT] && update);
    left_mode_c: cover property (@(posedge aclk) disable iff (!aresetn)
        converter_control_reg[CTL_LEFT_ADJUST_BIT] && update);
    read_shadow_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && s_axi_araddr == OFF_SHADOW);
    read_error_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && s_axi_araddr[1:0] != 2'h0);
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the converter update control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dac_ctrl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        aclk;
    logic        aresetn;
    logic [3:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic [7:0]  flags;
    logic [9:0]  conv_value;
    logic        conv_enable;
    logic        pin;
    int          err_count;
    int          compares;
    logic [9:0]  cur;

    dac_update_control dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_flags(flags), .converter_value(conv_value),
        .converter_enable(conv_enable), .analog_output_pin(pin)
    );

    // ****************************************
    // Clock, check and bus tasks
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h00_0000, d};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, (a[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR});
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, (a[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR});
        chk(rdata, exp);
    endtask

    // Flags change by non-blocking assignment; the rise is seen on the following edge
    task automatic set_flags(input logic [7:0] f);
        @(posedge aclk);
        flags <= f;
        repeat (3) @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(OFF_CONTROL, 32'h0000_0000);
        rd_chk(OFF_VALUE_HIGH, 32'h0000_0000);
        rd_chk(OFF_VALUE_LOW, 32'h0000_0000);
        rd_chk(OFF_SHADOW, 32'h0000_0000);
        chk({29'h0, conv_enable, pin, 1'b0}, 32'h0000_0000);
        // Unaligned offsets are refused, the shadow view ignores writes
        wr(4'h2, 8'hff);
        wr(OFF_SHADOW, 8'hff);
        rd_chk(4'h2, 32'h0000_0000);
        rd_chk(OFF_CONTROL, 32'h0000_0000);
        rd_chk(OFF_SHADOW, 32'h0000_0000);
    endtask

    // A trigger before any high write must not load a low-only value
    task automatic t_unarmed();
        wr(OFF_CONTROL, 8'h80);
        wr(OFF_VALUE_LOW, 8'h5a);
        set_flags(8'h01);
        set_flags(8'h00);
        chk({22'h0, conv_value}, 32'h0000_0000);
    endtask

    task automatic t_control();
        wr(OFF_CONTROL, 8'hff);
        rd_chk(OFF_CONTROL, 32'h0000_00f7);
        wr(OFF_CONTROL, 8'h03);
        chk({30'h0, conv_enable, pin}, 32'h0000_0003);
        wr(OFF_CONTROL, 8'h01);
        chk({30'h0, conv_enable, pin}, 32'h0000_0002);
        wr(OFF_CONTROL, 8'h00);
        chk({30'h0, conv_enable, pin}, 32'h0000_0000);
    endtask

    task automatic t_normal();
        wr(OFF_CONTROL, 8'h01);
        wr(OFF_VALUE_LOW, 8'ha5);
        chk({22'h0, conv_value}, 32'h0000_0000);
        wr(OFF_VALUE_HIGH, 8'h02);
        chk({22'h0, conv_value}, 32'h0000_02a5);
        rd_chk(OFF_SHADOW, 32'h0000_02a5);
        rd_chk(OFF_VALUE_HIGH, 32'h0000_0002);
    endtask

    task automatic t_left();
        wr(OFF_CONTROL, 8'h05);
        chk({22'h0, conv_value}, 32'h0000_02a5);
        wr(OFF_VALUE_HIGH, 8'hc3);
        chk({22'h0, conv_value}, 32'h0000_030e);
    endtask

    task automatic t_auto(input logic [2:0] code);
        logic [7:0] sel;
        logic [7:0] low;
        sel = 8'h01 << code;
        low = 8'h10 + {5'h0, code};
        wr(OFF_CONTROL, {1'b1, code, 4'h1});
        wr(OFF_VALUE_LOW, low);
        wr(OFF_VALUE_HIGH, 8'h01);
        chk({22'h0, conv_value}, {22'h0, cur});
        set_flags(~sel);
        set_flags(8'h00);
        chk({22'h0, conv_value}, {22'h0, cur});
        set_flags(sel);
        cur = {2'b01, low};
        chk({22'h0, conv_value}, {22'h0, cur});
        wr(OFF_VALUE_HIGH, 8'h03);
        repeat (4) @(posedge aclk);
        chk({22'h0, conv_value}, {22'h0, cur});
        set_flags(8'h00);
        set_flags(sel);
        cur = {2'b11, low};
        chk({22'h0, conv_value}, {22'h0, cur});
        set_flags(8'h00);
    endtask

    // ****************************************
    // Verdict and main sequence
    // ****************************************
    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0;
        compares  = 0;
        aresetn   = 1'b0;
        awaddr    = 4'h0;
        awvalid   = 1'b0;
        wdata     = 32'h0000_0000;
        wvalid    = 1'b0;
        bready    = 1'b0;
        araddr    = 4'h0;
        arvalid   = 1'b0;
        rready    = 1'b0;
        flags     = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_unarmed();
        t_control();
        t_normal();
        t_left();
        cur = 10'h30e;
        for (int c = 0; c < 8; c++) begin
            t_auto(c[2:0]);
        end
        summarize();
    end
endmodule
`default_nettype wire
